/* logic/ssc_pkg.sv */
// constants shared by the synchronous sram control block
`default_nettype none
package ssc_pkg;
  localparam int ADDR_W = 19;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int BEAT_W = 2;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [LANES-1:0] BW_N_RST = 4'hF;
  localparam logic [LANES-1:0] BW_N_NONE = 4'hF;
  localparam logic [LANES-1:0] BW_N_ALL = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  typedef enum logic {SSC_READ, SSC_WRITE} ssc_kind_t;
endpackage
`default_nettype wire

/* logic/ssc_sync2.sv */
// two-flop synchroniser for pins that change without regard to the clock
`default_nettype none
module ssc_sync2 (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pin in, synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

/* logic/ssc_ctrl.sv */
// control logic of a flow-through zero-latency synchronous sram
`default_nettype none
module ssc_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // asynchronous pins
  input wire logic sleep_request,
  input wire logic burst_mode,
  input wire logic output_enable_n,
  // synchronous control
  input wire logic clock_gate_n,
  input wire logic advance_load,
  input wire logic read_write,
  input wire logic chip_enable_n,
  input wire logic depth_expand_select,
  input wire logic depth_expand_n,
  input wire logic [ssc_pkg::ADDR_W-1:0] address,
  input wire logic byte_write_n_lane_a,
  input wire logic byte_write_n_lane_b,
  input wire logic byte_write_n_lane_c,
  input wire logic byte_write_n_lane_d,
  // data lanes, three signals per pin
  input wire logic [ssc_pkg::LANE_W-1:0] data_lane_a_in,
  input wire logic [ssc_pkg::LANE_W-1:0] data_lane_b_in,
  input wire logic [ssc_pkg::LANE_W-1:0] data_lane_c_in,
  input wire logic [ssc_pkg::LANE_W-1:0] data_lane_d_in,
  output logic [ssc_pkg::LANE_W-1:0] data_lane_a_out,
  output logic [ssc_pkg::LANE_W-1:0] data_lane_b_out,
  output logic [ssc_pkg::LANE_W-1:0] data_lane_c_out,
  output logic [ssc_pkg::LANE_W-1:0] data_lane_d_out,
  output logic data_lane_oe_n,
  // storage array port
  output logic [ssc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [ssc_pkg::DATA_W-1:0] mem_rdata,
  output logic mem_we,
  output logic [ssc_pkg::ADDR_W-1:0] mem_waddr,
  output logic [ssc_pkg::LANES-1:0] mem_wbe,
  output logic [ssc_pkg::DATA_W-1:0] mem_wdata,
  output logic standby
);
  import ssc_pkg::*;

  logic sleep_s;
  logic mode_s;
  logic oe_n_s;
  logic en;
  logic selected;
  logic [LANES-1:0] bw_n_in;
  logic [BEAT_W-1:0] cur_low;

  logic active_r, active_nxt;
  ssc_kind_t kind_r, kind_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [BEAT_W-1:0] beat_r, beat_nxt;
  logic [LANES-1:0] bw_n_r, bw_n_nxt;
  logic we_r, we_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [LANES-1:0] wbe_r, wbe_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;

  // the floating-high default of burst_mode is a pad pull-up; logic sees a level
  ssc_sync2 u_sleep (.clock(clock), .rst(rst), .d(sleep_request), .q(sleep_s));
  ssc_sync2 u_mode (.clock(clock), .rst(rst), .d(burst_mode), .q(mode_s));
  ssc_sync2 u_oe (.clock(clock), .rst(rst), .d(output_enable_n), .q(oe_n_s));

  // low address bits of beat n in either order
  function automatic logic [BEAT_W-1:0] burst_low(input logic [BEAT_W-1:0] first,
                                                  input logic [BEAT_W-1:0] beat,
                                                  input logic interleaved);
    if (interleaved) begin
      burst_low = first ^ beat;
    end else begin
      burst_low = first + beat;
    end
  endfunction

  assign en = !clock_gate_n && !sleep_s;
  assign selected = !chip_enable_n && !depth_expand_n && depth_expand_select;
  assign bw_n_in = {byte_write_n_lane_d, byte_write_n_lane_c,
                    byte_write_n_lane_b, byte_write_n_lane_a};
  assign cur_low = burst_low(base_r[BEAT_W-1:0], beat_r, mode_s);

  always_comb begin
    active_nxt = active_r;
    kind_nxt = kind_r;
    base_nxt = base_r;
    beat_nxt = beat_r;
    bw_n_nxt = bw_n_r;
    we_nxt = 1'b0;
    waddr_nxt = waddr_r;
    wbe_nxt = wbe_r;
    wdata_nxt = wdata_r;
    if (en) begin
      // the cycle registered at the previous edge is now in its data cycle
      if (active_r && kind_r == SSC_WRITE) begin
        we_nxt = (bw_n_r != BW_N_NONE);
        waddr_nxt = mem_addr;
        wbe_nxt = ~bw_n_r;
        wdata_nxt = {data_lane_d_in, data_lane_c_in,
                     data_lane_b_in, data_lane_a_in};
      end
      if (!advance_load) begin
        // chip selects and read_write only matter here
        active_nxt = selected;
        kind_nxt = read_write ? SSC_READ : SSC_WRITE;
        base_nxt = address;
        beat_nxt = BEAT_RST;
        bw_n_nxt = bw_n_in;
      end else if (active_r) begin
        // continuation keeps kind, the counter moves and the byte writes are taken again
        beat_nxt = beat_r + BEAT_STEP;
        bw_n_nxt = bw_n_in;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      active_r <= 1'b0;
      kind_r <= SSC_READ;
      base_r <= ADDR_RST;
      beat_r <= BEAT_RST;
      bw_n_r <= BW_N_RST;
      we_r <= 1'b0;
      waddr_r <= ADDR_RST;
      wbe_r <= ~BW_N_RST;
      wdata_r <= DATA_RST;
    end else begin
      active_r <= active_nxt;
      kind_r <= kind_nxt;
      base_r <= base_nxt;
      beat_r <= beat_nxt;
      bw_n_r <= bw_n_nxt;
      we_r <= we_nxt;
      waddr_r <= waddr_nxt;
      wbe_r <= wbe_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign mem_addr = {base_r[ADDR_W-1:BEAT_W], cur_low};
  assign mem_we = we_r;
  assign mem_waddr = waddr_r;
  assign mem_wbe = wbe_r;
  assign mem_wdata = wdata_r;
  // standby only stops accesses; the array itself keeps its words
  assign standby = sleep_s;
  // flow-through: read data goes straight from the array to the pins
  assign data_lane_a_out = mem_rdata[LANE_W-1:0];
  assign data_lane_b_out = mem_rdata[2*LANE_W-1:LANE_W];
  assign data_lane_c_out = mem_rdata[3*LANE_W-1:2*LANE_W];
  assign data_lane_d_out = mem_rdata[4*LANE_W-1:3*LANE_W];
  // a stalled read keeps driving, a write never drives
  assign data_lane_oe_n = sleep_s || oe_n_s || !active_r || kind_r == SSC_WRITE;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sleep_hiz: assert property (sleep_s |-> data_lane_oe_n)
    else $error("data driven during sleep");
  a_sleep_frozen: assert property (sleep_s |=> $stable(base_r) && $stable(beat_r)
                                   && $stable(active_r) && !mem_we)
    else $error("state moved during sleep");
  a_type_on_load: assert property (en && !advance_load |=>
                                   (kind_r == SSC_WRITE) == !$past(read_write))
    else $error("cycle type not taken from read_write");
  a_type_kept: assert property (en && advance_load |=> $stable(kind_r))
    else $error("burst type changed without a load");
  a_abort_nowrite: assert property (en && active_r && kind_r == SSC_WRITE
                                    && bw_n_r == BW_N_NONE |=> !mem_we)
    else $error("write issued with no byte enable");
  a_full_write: assert property (en && active_r && kind_r == SSC_WRITE
                                 && bw_n_r == BW_N_ALL |=> mem_we && mem_wbe == 4'hF)
    else $error("full word write missing lanes");
  a_lane_capture: assert property (en && active_r && kind_r == SSC_WRITE |=>
                                   mem_wdata[LANE_W-1:0] == $past(data_lane_a_in)
                                   && mem_wbe[0] == !$past(bw_n_r[0]))
    else $error("lane a data or enable wrong");
  a_linear_order: assert property (active_r && !mode_s |->
                                   mem_addr[1:0] == 2'(base_r[1:0] + beat_r))
    else $error("linear order wrong");
  a_inter_order: assert property (active_r && mode_s |->
                                  mem_addr[1:0] == (base_r[1:0] ^ beat_r))
    else $error("interleaved order wrong");
  a_stall_hold: assert property (clock_gate_n |=> $stable(base_r) && $stable(beat_r)
                                 && !mem_we)
    else $error("state moved on ignored edge");
  a_cs_ignored: assert property (en && advance_load && active_r |=> active_r
                                 && beat_r == 2'($past(beat_r) + 2'h1))
    else $error("continuation dropped or did not advance");
  a_write_hiz: assert property (active_r && kind_r == SSC_WRITE |-> data_lane_oe_n)
    else $error("data driven during write");

  c_read_burst: cover property (en && !advance_load && selected && read_write
                                ##1 (en && advance_load) [*3]);
  c_write_burst: cover property (en && !advance_load && selected && !read_write
                                 ##1 mem_we);
  c_stall_read: cover property (active_r && kind_r == SSC_READ && clock_gate_n);
  c_sleep: cover property (active_r ##1 sleep_s);
endmodule
`default_nettype wire

/* testbench/ssc_array_model.sv */
// storage array model on the far side of the control block's array port
`default_nettype none
module ssc_array_model (
  // clock
  input wire logic clock,
  // array port
  input wire logic [ssc_pkg::ADDR_W-1:0] mem_addr,
  output logic [ssc_pkg::DATA_W-1:0] mem_rdata,
  input wire logic mem_we,
  input wire logic [ssc_pkg::ADDR_W-1:0] mem_waddr,
  input wire logic [ssc_pkg::LANES-1:0] mem_wbe,
  input wire logic [ssc_pkg::DATA_W-1:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;
  logic [DATA_W-1:0] arr [0:63];
  // unwritten words hold a per-address pattern so stale data never passes
  initial begin
    for (int i = 0; i < 64; i++) arr[i] = {4{i[8:0]}};
  end
  assign mem_rdata = arr[mem_addr[5:0]];
  // lanes merge one by one, untouched lanes keep their old contents
  always @(posedge clock) begin
    for (int l = 0; l < LANES; l++) begin
      if (mem_we && mem_wbe[l]) arr[mem_waddr[5:0]][l*LANE_W +: LANE_W] <= mem_wdata[l*LANE_W +: LANE_W];
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the synchronous sram control block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sleep_request = 1'b0;
  logic burst_mode = 1'b0;
  logic clock_gate_n = 1'b0;
  logic advance_load = 1'b1;
  logic read_write = 1'b1;
  logic chip_enable_n = 1'b1;
  logic [ADDR_W-1:0] address = ADDR_RST;
  logic [LANES-1:0] bw_n = BW_N_NONE;
  logic [DATA_W-1:0] din = DATA_RST;
  wire [DATA_W-1:0] dout;
  logic [DATA_W-1:0] mem_rdata, mem_wdata;
  logic [DATA_W-1:0] sh [0:63];
  logic [ADDR_W-1:0] mem_addr, mem_waddr;
  logic [LANES-1:0] mem_wbe;
  logic oe_n, mem_we, standby;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  ssc_ctrl DUT (.clock(clock), .rst(rst), .sleep_request(sleep_request), .burst_mode(burst_mode),
    .output_enable_n(1'b0), .clock_gate_n(clock_gate_n), .advance_load(advance_load),
    .read_write(read_write), .chip_enable_n(chip_enable_n), .depth_expand_select(1'b1),
    .depth_expand_n(1'b0), .address(address), .byte_write_n_lane_a(bw_n[0]),
    .byte_write_n_lane_b(bw_n[1]), .byte_write_n_lane_c(bw_n[2]), .byte_write_n_lane_d(bw_n[3]),
    .data_lane_a_in(din[8:0]), .data_lane_b_in(din[17:9]), .data_lane_c_in(din[26:18]),
    .data_lane_d_in(din[35:27]), .data_lane_a_out(dout[8:0]), .data_lane_b_out(dout[17:9]),
    .data_lane_c_out(dout[26:18]), .data_lane_d_out(dout[35:27]), .data_lane_oe_n(oe_n),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wbe(mem_wbe), .mem_wdata(mem_wdata), .standby(standby));
  ssc_array_model ARR (.clock(clock), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wbe(mem_wbe), .mem_wdata(mem_wdata));
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang ends the run as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic al, input logic rw, input logic ce_n, input logic [ADDR_W-1:0] a,
                     input logic [LANES-1:0] bn, input logic [DATA_W-1:0] d);
    @(negedge clock);
    advance_load = al;
    read_write = rw;
    chip_enable_n = ce_n;
    address = a;
    bw_n = bn;
    din = d;
  endtask
  // load a write, give its data next cycle, then watch the array port
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bn,
                    input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    for (int l = 0; l < LANES; l++) m[l*LANE_W +: LANE_W] = {LANE_W{~bn[l]}};
    cmd(1'b0, 1'b0, 1'b0, a, bn, DATA_RST);
    cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, d);
    chk(oe_n, 1'b1);
    @(negedge clock);
    chk(mem_we, bn != BW_N_NONE);
    if (bn != BW_N_NONE) begin
      chk(mem_waddr, a);
      chk(mem_wbe, 4'(~bn));
      chk(mem_wdata & m, d & m);
      sh[a[5:0]] = (sh[a[5:0]] & ~m) | (d & m);
    end
  endtask
  // continuations try to turn the read into a write and drop the selects
  task automatic rd_burst(input logic [ADDR_W-1:0] a, input logic il);
    logic [ADDR_W-1:0] e;
    cmd(1'b0, 1'b1, 1'b0, a, BW_N_ALL, DATA_RST);
    for (int k = 0; k < 5; k++) begin
      cmd(1'b1, 1'b0, 1'b1, ADDR_RST, BW_N_ALL, DATA_RST);
      e = a;
      e[1:0] = il ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
      chk(mem_addr, e);
      chk(oe_n, 1'b0);
      chk(mem_we, 1'b0);
      chk(dout, sh[e[5:0]]);
    end
    cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, DATA_RST);
  endtask
  task automatic t_write();
    wr(19'h00004, BW_N_ALL, 36'h123456789);
    wr(19'h00005, BW_N_NONE, 36'h0F0F0F0F0);
    for (int l = 0; l < LANES; l++) wr(19'h00010, ~(4'h1 << l), 36'h1F3E5D7BC + l);
    rd_burst(19'h00010, 1'b0);
    $display("test write done");
  endtask
  // write burst whose continuations raise read_write; every beat must still write
  task automatic t_wburst();
    logic [ADDR_W-1:0] e;
    logic [DATA_W-1:0] d;
    cmd(1'b0, 1'b0, 1'b0, 19'h00032, BW_N_ALL, DATA_RST);
    for (int k = 0; k < 5; k++) begin
      d = 36'h0A5A5A5A0 + 36'(k);
      if (k < 3) begin
        cmd(1'b1, 1'b1, 1'b1, ADDR_RST, BW_N_ALL, d);
      end else if (k == 3) begin
        cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, d);
      end else begin
        @(negedge clock);
      end
      chk(oe_n, 1'b1);
      if (k > 0) begin
        e = 19'h00032;
        e[1:0] = 2'h2 + 2'(k - 1);
        chk(mem_we, 1'b1);
        chk(mem_waddr, e);
        chk(mem_wbe, 4'(~BW_N_ALL));
        chk(mem_wdata, 36'h0A5A5A5A0 + 36'(k - 1));
        sh[e[5:0]] = 36'h0A5A5A5A0 + 36'(k - 1);
      end
    end
    rd_burst(19'h00030, 1'b0);
    $display("test write burst done");
  endtask
  task automatic t_burst();
    rd_burst(19'h00021, 1'b0);
    burst_mode = 1'b1;
    repeat (3) @(negedge clock);
    rd_burst(19'h00022, 1'b1);
    rd_burst(19'h00013, 1'b1);
    burst_mode = 1'b0;
    repeat (3) @(negedge clock);
    $display("test burst done");
  endtask
  task automatic t_gate();
    cmd(1'b0, 1'b1, 1'b0, 19'h00008, BW_N_NONE, DATA_RST);
    cmd(1'b1, 1'b1, 1'b0, ADDR_RST, BW_N_NONE, DATA_RST);
    clock_gate_n = 1'b1;
    repeat (3) begin
      @(negedge clock);
      chk(mem_addr, 19'h00008);
    end
    clock_gate_n = 1'b0;
    @(negedge clock);
    chk(mem_addr, 19'h00009);
    cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, DATA_RST);
    $display("test gate done");
  endtask
  task automatic t_sleep();
    sleep_request = 1'b1;
    repeat (4) @(negedge clock);
    chk(standby, 1'b1);
    chk(oe_n, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 19'h00004, BW_N_ALL, DATA_RST);
    cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, 36'hFFFFFFFFF);
    repeat (2) begin
      @(negedge clock);
      chk(mem_we, 1'b0);
    end
    sleep_request = 1'b0;
    repeat (4) @(negedge clock);
    chk(standby, 1'b0);
    rd_burst(19'h00004, 1'b0);
    $display("test sleep done");
  endtask
  task automatic t_desel();
    cmd(1'b0, 1'b1, 1'b1, 19'h00008, BW_N_NONE, DATA_RST);
    cmd(1'b1, 1'b1, 1'b0, ADDR_RST, BW_N_NONE, DATA_RST);
    chk(oe_n, 1'b1);
    @(negedge clock);
    chk(oe_n, 1'b1);
    cmd(1'b0, 1'b1, 1'b1, ADDR_RST, BW_N_NONE, DATA_RST);
    $display("test deselect done");
  endtask
  initial begin
    for (int i = 0; i < 64; i++) sh[i] = {4{i[8:0]}};
    repeat (10) @(negedge clock);
    rst = 1'b0;
    chk(oe_n, 1'b1);
    chk(mem_we, 1'b0);
    repeat (3) @(negedge clock);
    t_write();
    t_wburst();
    t_burst();
    t_gate();
    t_sleep();
    t_desel();
    test_done();
  end
endmodule
`default_nettype wire
